//--- logic/cpu_register_set.sv
`include "crs_defines.svh"
`default_nettype none
module cpu_register_set (
  // clock, reset, enable
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  // decoder and alu side
  input  wire crs_pkg::op_e  i_op,
  input  wire crs_pkg::sel_e i_sel,
  input  wire logic [7:0]   i_data,
  input  wire logic         i_carry,
  input  wire logic         i_half,
  input  wire logic [15:0]  i_target,
  input  wire logic [1:0]   i_isr_mask,
  output logic              o_busy,
  // stack memory side
  output logic [15:0]       o_stk_addr,
  output logic              o_stk_we,
  output logic              o_stk_re,
  output logic [7:0]        o_stk_wdata,
  input  wire logic [7:0]   i_stk_rdata,
  // register views
  output logic [7:0]        o_acc,
  output logic [7:0]        o_idx_x,
  output logic [7:0]        o_idx_y,
  output logic [15:0]       o_pc,
  output logic [7:0]        o_cc,
  output logic [15:0]       o_sp
);
  crs_pkg::state_s r;
  crs_pkg::state_s next_r;
  logic            idle;
  logic            take;

  // read one selected register
  function automatic logic [7:0] get_sel(crs_pkg::state_s s,
                                         crs_pkg::sel_e sel);
    unique case (sel)
      crs_pkg::SEL_A:   get_sel = s.acc;
      crs_pkg::SEL_X:   get_sel = s.idx_x;
      crs_pkg::SEL_Y:   get_sel = s.idx_y;
      crs_pkg::SEL_CC:  get_sel = s.cc;
      crs_pkg::SEL_SPL: get_sel = s.sp_low;
      crs_pkg::SEL_PCL: get_sel = s.pc[7:0];
      crs_pkg::SEL_PCH: get_sel = s.pc[15:8];
      default:          get_sel = 8'h00;
    endcase
  endfunction

  // write one selected register; flag bits 7,6 stay one
  function automatic crs_pkg::state_s put_sel(crs_pkg::state_s s,
                                              crs_pkg::sel_e sel,
                                              logic [7:0] d);
    put_sel = s;
    unique case (sel)
      crs_pkg::SEL_A:   put_sel.acc = d;
      crs_pkg::SEL_X:   put_sel.idx_x = d;
      crs_pkg::SEL_Y:   put_sel.idx_y = d;
      crs_pkg::SEL_CC:  put_sel.cc = d | `CRS_CC_FIXED;
      crs_pkg::SEL_SPL: put_sel.sp_low = d;
      crs_pkg::SEL_PCL: put_sel.pc[7:0] = d;
      crs_pkg::SEL_PCH: put_sel.pc[15:8] = d;
      default:          put_sel = s;
    endcase
  endfunction

  // which context byte a sequence step handles
  function automatic crs_pkg::sel_e seq_sel(crs_pkg::seq_e q,
                                            logic [2:0] st);
    logic [2:0] item;
    item = st;
    if (q == crs_pkg::SEQ_INTERRUPT_RETURN_INSTRUCTION) begin
      item = `CRS_IRQ_LAST - st;
    end else if (q == crs_pkg::SEQ_RET) begin
      item = `CRS_CALL_LAST - st;
    end
    unique case (item)
      3'h0:    seq_sel = crs_pkg::SEL_PCL;
      3'h1:    seq_sel = crs_pkg::SEL_PCH;
      3'h2:    seq_sel = crs_pkg::SEL_X;
      3'h3:    seq_sel = crs_pkg::SEL_A;
      default: seq_sel = crs_pkg::SEL_CC;
    endcase
  endfunction

  // result flags n and z from a result byte
  function automatic logic [7:0] nz(logic [7:0] cc, logic [7:0] d);
    nz = cc;
    nz[`CRS_CC_N] = d[7];
    nz[`CRS_CC_Z] = (d == 8'h00);
  endfunction

  assign idle = (r.seq == crs_pkg::SEQ_IDLE);
  assign take = i_ce && idle;
  assign o_busy = !idle;

  // stack strobes; upper address byte is the fixed page
  always_comb begin
    o_stk_we    = 1'b0;
    o_stk_re    = 1'b0;
    o_stk_addr  = {`CRS_SP_PAGE, r.sp_low};
    o_stk_wdata = 8'h00;
    unique case (r.seq)
      crs_pkg::SEQ_IDLE: begin
        if (take && i_op == crs_pkg::OP_PUSH) begin
          o_stk_we    = 1'b1;
          o_stk_wdata = get_sel(r, i_sel);
        end else if (take && i_op == crs_pkg::OP_POP) begin
          o_stk_re   = 1'b1;
          o_stk_addr = {`CRS_SP_PAGE, r.sp_low + 8'h01};
        end
      end
      crs_pkg::SEQ_IRQ, crs_pkg::SEQ_CALL: begin
        o_stk_we    = i_ce;
        o_stk_wdata = get_sel(r, seq_sel(r.seq, r.step));
      end
      crs_pkg::SEQ_INTERRUPT_RETURN_INSTRUCTION, crs_pkg::SEQ_RET: begin
        o_stk_re   = i_ce;
        o_stk_addr = {`CRS_SP_PAGE, r.sp_low + 8'h01};
      end
    endcase
  end

  // next state: idle operations and stack sequences
  always_comb begin
    next_r = r;
    if (i_ce) begin
      unique case (r.seq)
        crs_pkg::SEQ_IDLE: begin
          unique case (i_op)
            crs_pkg::OP_NOP: next_r = r;
            crs_pkg::OP_WRITE: next_r = put_sel(r, i_sel, i_data);
            crs_pkg::OP_ADD: begin
              next_r = put_sel(r, i_sel, i_data);
              next_r.cc = nz(next_r.cc, i_data);
              next_r.cc[`CRS_CC_H] = i_half;
              next_r.cc[`CRS_CC_C] = i_carry;
            end
            crs_pkg::OP_ARITH: begin
              next_r = put_sel(r, i_sel, i_data);
              next_r.cc = nz(next_r.cc, i_data);
              next_r.cc[`CRS_CC_C] = i_carry;
            end
            crs_pkg::OP_LOGIC: begin
              next_r = put_sel(r, i_sel, i_data);
              next_r.cc = nz(next_r.cc, i_data);
            end
            crs_pkg::OP_SCF: next_r.cc[`CRS_CC_C] = 1'b1;
            crs_pkg::OP_RCF: next_r.cc[`CRS_CC_C] = 1'b0;
            crs_pkg::OP_CARRY: next_r.cc[`CRS_CC_C] = i_carry;
            crs_pkg::OP_MASK: begin
              // i_isr_mask is {level high bit, level low bit}
              next_r.cc[`CRS_CC_I1] = i_isr_mask[1];
              next_r.cc[`CRS_CC_I0] = i_isr_mask[0];
            end
            crs_pkg::OP_PUSH: next_r.sp_low = r.sp_low - 8'h01;
            crs_pkg::OP_POP: begin
              next_r = put_sel(r, i_sel, i_stk_rdata);
              next_r.sp_low = r.sp_low + 8'h01;
            end
            crs_pkg::OP_CALL: begin
              next_r.seq    = crs_pkg::SEQ_CALL;
              next_r.step   = 3'h0;
              next_r.target = i_target;
            end
            crs_pkg::OP_RET: begin
              next_r.seq  = crs_pkg::SEQ_RET;
              next_r.step = 3'h0;
            end
            crs_pkg::OP_IRQ: begin
              // mask and vector caught now, applied after the pushes
              next_r.seq      = crs_pkg::SEQ_IRQ;
              next_r.step     = 3'h0;
              next_r.target   = i_target;
              next_r.isr_mask = i_isr_mask;
            end
            crs_pkg::OP_INTERRUPT_RETURN_INSTRUCTION: begin
              next_r.seq  = crs_pkg::SEQ_INTERRUPT_RETURN_INSTRUCTION;
              next_r.step = 3'h0;
            end
            crs_pkg::OP_RSP: next_r.sp_low = `CRS_SP_LOW;
          endcase
        end
        crs_pkg::SEQ_IRQ, crs_pkg::SEQ_CALL: begin
          next_r.sp_low = r.sp_low - 8'h01;
          next_r.step   = r.step + 3'h1;
          if (r.step == ((r.seq == crs_pkg::SEQ_IRQ) ?
                         `CRS_IRQ_LAST : `CRS_CALL_LAST)) begin
            next_r.seq = crs_pkg::SEQ_IDLE;
            next_r.pc  = r.target;
            if (r.seq == crs_pkg::SEQ_IRQ) begin
              next_r.cc[`CRS_CC_I1] = r.isr_mask[1];
              next_r.cc[`CRS_CC_I0] = r.isr_mask[0];
            end
          end
        end
        crs_pkg::SEQ_INTERRUPT_RETURN_INSTRUCTION, crs_pkg::SEQ_RET: begin
          next_r = put_sel(r, seq_sel(r.seq, r.step), i_stk_rdata);
          next_r.sp_low = r.sp_low + 8'h01;
          next_r.step   = r.step + 3'h1;
          if (r.step == ((r.seq == crs_pkg::SEQ_INTERRUPT_RETURN_INSTRUCTION) ?
                         `CRS_IRQ_LAST : `CRS_CALL_LAST)) begin
            next_r.seq = crs_pkg::SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // state register; undefined flag bits reset to zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r <= '{acc: 8'h00, idx_x: 8'h00, idx_y: 8'h00,
             cc: `CRS_CC_RESET, sp_low: `CRS_SP_LOW,
             pc: 16'h0000, seq: crs_pkg::SEQ_IDLE, step: 3'h0,
             target: 16'h0000, isr_mask: 2'h0};
    end else begin
      r <= next_r;
    end
  end

  // register views from flip-flops; stack pointer high byte is the fixed page
  assign o_acc   = r.acc;
  assign o_idx_x = r.idx_x;
  assign o_idx_y = r.idx_y;
  assign o_pc    = r.pc;
  assign o_cc    = r.cc;
  assign o_sp    = {`CRS_SP_PAGE, r.sp_low};

  // checks
  sequence s_irq_take;
    take && i_op == crs_pkg::OP_IRQ;
  endsequence
  sequence s_irq_run;
    s_irq_take ##1 i_ce [*5];
  endsequence

  property p_sp_page;
    @(posedge i_clk) disable iff (i_rst) o_sp[15:8] == 8'h01;
  endproperty
  a_sp_page: assert property (p_sp_page)
    else $error("stack page moved");

  property p_cc_fixed;
    @(posedge i_clk) disable iff (i_rst) o_cc[7:6] == 2'b11;
  endproperty
  a_cc_fixed: assert property (p_cc_fixed)
    else $error("fixed flag bits lost");

  property p_push_dec;
    @(posedge i_clk) disable iff (i_rst)
      take && i_op == crs_pkg::OP_PUSH |=>
        o_sp[7:0] == $past(o_sp[7:0]) - 8'h01;
  endproperty
  a_push_dec: assert property (p_push_dec)
    else $error("push did not decrement");

  property p_rsp;
    @(posedge i_clk) disable iff (i_rst)
      take && i_op == crs_pkg::OP_RSP |=> o_sp == 16'h01FF;
  endproperty
  a_rsp: assert property (p_rsp)
    else $error("stack reset value wrong");

  property p_zero_neg;
    @(posedge i_clk) disable iff (i_rst)
      take && i_op == crs_pkg::OP_LOGIC |=>
        o_cc[1] == ($past(i_data) == 8'h00) &&
        o_cc[2] == $past(i_data[7]);
  endproperty
  a_zero_neg: assert property (p_zero_neg)
    else $error("zero or negative flag wrong");

  property p_half;
    @(posedge i_clk) disable iff (i_rst)
      take && i_op == crs_pkg::OP_ADD |=> o_cc[4] == $past(i_half);
  endproperty
  a_half: assert property (p_half)
    else $error("half carry wrong");

  property p_first_pcl;
    @(posedge i_clk) disable iff (i_rst)
      s_irq_take ##1 i_ce |->
        o_stk_we && o_stk_wdata == o_pc[7:0] && o_stk_addr == o_sp;
  endproperty
  a_first_pcl: assert property (p_first_pcl)
    else $error("first pushed byte not pc low");

  property p_irq_five;
    @(posedge i_clk) disable iff (i_rst)
      s_irq_run |=>
        !o_busy && o_sp[7:0] == $past(o_sp[7:0], 5) - 8'h05;
  endproperty
  a_irq_five: assert property (p_irq_five)
    else $error("interrupt did not use five bytes");

  property p_irq_mask;
    @(posedge i_clk) disable iff (i_rst)
      s_irq_run |=>
        {o_cc[5], o_cc[3]} == $past(i_isr_mask, 6);
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("priority mask not loaded");

  property p_y_kept;
    @(posedge i_clk) disable iff (i_rst) o_busy |=> $stable(o_idx_y);
  endproperty
  a_y_kept: assert property (p_y_kept)
    else $error("second index changed by sequence");
endmodule
`default_nettype wire

//--- include/crs_defines.svh
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH
// condition flag bit positions
`define CRS_CC_C     0
`define CRS_CC_Z     1
`define CRS_CC_N     2
`define CRS_CC_I0    3
`define CRS_CC_H     4
`define CRS_CC_I1    5
// bits 7 and 6 always read one; undefined reset bits taken as zero
`define CRS_CC_FIXED 8'hC0
`define CRS_CC_RESET 8'hE8
// stack window
`define CRS_SP_RESET 16'h01FF
`define CRS_SP_PAGE  8'h01
`define CRS_SP_LOW   8'hFF
// context bytes per sequence, minus one
`define CRS_IRQ_LAST  3'h4
`define CRS_CALL_LAST 3'h1
`endif

//--- include/crs_pkg.sv
`default_nettype none
package crs_pkg;
  // operations issued by the decoder
  typedef enum logic [3:0] {
    OP_NOP, OP_WRITE, OP_ADD, OP_ARITH, OP_LOGIC, OP_SCF, OP_RCF,
    OP_CARRY, OP_MASK, OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_IRQ,
    OP_INTERRUPT_RETURN_INSTRUCTION, OP_RSP
  } op_e;
  // register select for single writes, push and pop
  typedef enum logic [2:0] {
    SEL_A, SEL_X, SEL_Y, SEL_CC, SEL_SPL, SEL_PCL, SEL_PCH
  } sel_e;
  // multi-byte stack sequences
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_IRQ, SEQ_CALL, SEQ_INTERRUPT_RETURN_INSTRUCTION, SEQ_RET
  } seq_e;
  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  idx_x;
    logic [7:0]  idx_y;
    logic [7:0]  cc;
    logic [7:0]  sp_low;
    logic [15:0] pc;
    seq_e        seq;
    logic [2:0]  step;
    logic [15:0] target;
    logic [1:0]  isr_mask;
  } state_s;
endpackage
`default_nettype wire

//--- dv/stack_memory_model.sv
`default_nettype none
module stack_memory_model (
  // clock
  input  wire logic        i_clk,
  // stack port
  input  wire logic [15:0] i_addr,
  input  wire logic        i_we,
  input  wire logic        i_re,
  input  wire logic [7:0]  i_wdata,
  output logic [7:0]       o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  // writes land on the edge, one byte per strobe
  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr[7:0]] <= i_wdata;
    end
  end
  // remember the last byte read for the idle pattern
  always @(posedge i_clk) begin
    if (i_re) begin
      last <= mem[i_addr[7:0]];
    end
  end
  // idle data is inverted so a late sample never looks right
  assign o_rdata = i_re ? mem[i_addr[7:0]] : ~last;
endmodule
`default_nettype wire

//--- dv/cpu_core_register_set_tb.sv
`default_nettype none
module cpu_core_register_set_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1;
  crs_pkg::op_e i_op = crs_pkg::OP_NOP;
  crs_pkg::sel_e i_sel = crs_pkg::SEL_A;
  logic [7:0] i_data = 8'h00, stk_rd, acc, ix, iy, cc, wd;
  logic i_carry = 1'b0, i_half = 1'b0, busy, we, re;
  logic [15:0] i_target = 16'h0000, sa, pc, sp;
  logic [1:0] i_isr_mask = 2'b00;
  int n_fail = 0, n_checks = 0, nb = 0, cyc = 0;

  cpu_register_set DUT (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_op(i_op), .i_sel(i_sel), .i_data(i_data), .i_carry(i_carry),
    .i_half(i_half), .i_target(i_target), .i_isr_mask(i_isr_mask),
    .o_busy(busy), .o_stk_addr(sa), .o_stk_we(we), .o_stk_re(re),
    .o_stk_wdata(wd), .i_stk_rdata(stk_rd), .o_acc(acc), .o_idx_x(ix),
    .o_idx_y(iy), .o_pc(pc), .o_cc(cc), .o_sp(sp));
  stack_memory_model mdl (.i_clk(i_clk), .i_addr(sa), .i_we(we),
    .i_re(re), .i_wdata(wd), .o_rdata(stk_rd));

  // 200 MHz clock and a hang guard
  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic chk(input logic [15:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one op, then wait out any sequence, counting busy cycles
  task automatic issue(input crs_pkg::op_e op, crs_pkg::sel_e s,
                       logic [7:0] d);
    @(posedge i_clk);
    i_op <= op;
    i_sel <= s;
    i_data <= d;
    @(posedge i_clk);
    i_op <= crs_pkg::OP_NOP;
    #1;
    nb = 0;
    while (busy === 1'b1 && nb < 20) begin
      @(posedge i_clk);
      #1;
      nb++;
    end
  endtask

  task automatic t_reset();
    chk({acc, ix}, 16'h0000, "acc x");
    chk({iy, cc}, 16'h00E8, "y cc");
    chk(pc, 16'h0000, "pc");
    chk(sp, 16'h01FF, "sp");
    $display("test reset done");
  endtask

  task automatic t_regs();
    issue(crs_pkg::OP_WRITE, crs_pkg::SEL_A, 8'h3C);
    issue(crs_pkg::OP_WRITE, crs_pkg::SEL_X, 8'hA5);
    issue(crs_pkg::OP_WRITE, crs_pkg::SEL_Y, 8'h5A);
    issue(crs_pkg::OP_WRITE, crs_pkg::SEL_SPL, 8'h80);
    chk({acc, ix}, 16'h3CA5, "acc x write");
    chk({8'h00, iy}, 16'h005A, "y write");
    chk(sp, 16'h0180, "sp low load");
    issue(crs_pkg::OP_WRITE, crs_pkg::SEL_CC, 8'h00);
    chk({8'h00, cc}, 16'h00C0, "cc write");
    // clock enable low must swallow the op
    @(posedge i_clk);
    i_ce <= 1'b0;
    issue(crs_pkg::OP_WRITE, crs_pkg::SEL_A, 8'hFF);
    chk({8'h00, acc}, 16'h003C, "ce low");
    @(posedge i_clk);
    i_ce <= 1'b1;
    $display("test regs done");
  endtask

  task automatic t_flags();
    @(posedge i_clk);
    i_half <= 1'b1;
    i_carry <= 1'b1;
    issue(crs_pkg::OP_ADD, crs_pkg::SEL_A, 8'h80);
    chk({acc, cc}, 16'h80D5, "add hnc");
    @(posedge i_clk);
    i_half <= 1'b0;
    i_carry <= 1'b0;
    issue(crs_pkg::OP_ADD, crs_pkg::SEL_A, 8'h00);
    chk({8'h00, cc}, 16'h00C2, "add z");
    issue(crs_pkg::OP_SCF, crs_pkg::SEL_A, 8'h00);
    chk({15'h0000, cc[0]}, 16'h0001, "set carry");
    issue(crs_pkg::OP_RCF, crs_pkg::SEL_A, 8'h00);
    chk({15'h0000, cc[0]}, 16'h0000, "reset carry");
    @(posedge i_clk);
    i_carry <= 1'b1;
    issue(crs_pkg::OP_CARRY, crs_pkg::SEL_A, 8'h00);
    chk({15'h0000, cc[0]}, 16'h0001, "carry op");
    // other arithmetic results drive n, z and c; logic results drive only n and z
    issue(crs_pkg::OP_ARITH, crs_pkg::SEL_X, 8'h7F);
    chk({ix, cc}, 16'h7FC1, "arith c");
    issue(crs_pkg::OP_LOGIC, crs_pkg::SEL_X, 8'h80);
    chk({ix, cc}, 16'h80C5, "logic n");
    issue(crs_pkg::OP_LOGIC, crs_pkg::SEL_X, 8'h00);
    chk({ix, cc}, 16'h00C3, "logic z");
    // every priority level through the mask op
    for (int l = 0; l < 4; l++) begin
      @(posedge i_clk);
      i_isr_mask <= 2'(l);
      issue(crs_pkg::OP_MASK, crs_pkg::SEL_A, 8'h00);
      chk({14'h0000, cc[5], cc[3]}, 16'(l), "mask");
    end
    $display("test flags done");
  endtask

  task automatic t_wrap();
    issue(crs_pkg::OP_WRITE, crs_pkg::SEL_A, 8'h3C);
    issue(crs_pkg::OP_WRITE, crs_pkg::SEL_SPL, 8'h00);
    issue(crs_pkg::OP_PUSH, crs_pkg::SEL_A, 8'h00);
    chk({8'h00, mdl.mem[0]}, 16'h003C, "push byte");
    chk(sp, 16'h01FF, "push wrap");
    issue(crs_pkg::OP_POP, crs_pkg::SEL_X, 8'h00);
    chk({ix, 8'h00}, 16'h3C00, "pop byte");
    chk(sp, 16'h0100, "pop wrap");
    issue(crs_pkg::OP_RSP, crs_pkg::SEL_A, 8'h00);
    chk(sp, 16'h01FF, "stack reset op");
    $display("test wrap done");
  endtask

  task automatic t_ctx();
    issue(crs_pkg::OP_WRITE, crs_pkg::SEL_A, 8'h11);
    issue(crs_pkg::OP_WRITE, crs_pkg::SEL_X, 8'h22);
    issue(crs_pkg::OP_WRITE, crs_pkg::SEL_CC, 8'h01);
    @(posedge i_clk);
    i_target <= 16'h1234;
    issue(crs_pkg::OP_CALL, crs_pkg::SEL_A, 8'h00);
    chk(16'(nb), 16'h0002, "call bytes");
    chk(pc, 16'h1234, "call pc");
    chk(sp, 16'h01FD, "call sp");
    @(posedge i_clk);
    i_target <= 16'hABCD;
    i_isr_mask <= 2'b01;
    issue(crs_pkg::OP_IRQ, crs_pkg::SEL_A, 8'h00);
    chk(16'(nb), 16'h0005, "irq bytes");
    chk({mdl.mem[8'hFD], mdl.mem[8'hFC]}, 16'h3412, "irq pc");
    chk({mdl.mem[8'hFB], mdl.mem[8'hFA]}, 16'h2211, "irq x a");
    chk({8'h00, mdl.mem[8'hF9]}, 16'h00C1, "irq cc");
    chk({cc, iy}, 16'hC95A, "irq mask y");
    chk(pc, 16'hABCD, "irq pc load");
    issue(crs_pkg::OP_WRITE, crs_pkg::SEL_A, 8'h77);
    issue(crs_pkg::OP_WRITE, crs_pkg::SEL_X, 8'h88);
    issue(crs_pkg::OP_INTERRUPT_RETURN_INSTRUCTION, crs_pkg::SEL_A, 8'h00);
    chk({acc, ix}, 16'h1122, "interrupt_return_instruction a x");
    chk({cc, iy}, 16'hC15A, "interrupt_return_instruction cc y");
    chk(pc, 16'h1234, "interrupt_return_instruction pc");
    chk(sp, 16'h01FD, "interrupt_return_instruction sp");
    issue(crs_pkg::OP_RET, crs_pkg::SEL_A, 8'h00);
    chk(pc, 16'h0000, "ret pc");
    chk(sp, 16'h01FF, "ret sp");
    $display("test context done");
  endtask

  // reset lands while an interrupt push is in flight
  task automatic t_mid_reset();
    issue(crs_pkg::OP_WRITE, crs_pkg::SEL_PCH, 8'h56);
    issue(crs_pkg::OP_WRITE, crs_pkg::SEL_PCL, 8'h78);
    chk(pc, 16'h5678, "pc bytes");
    @(posedge i_clk);
    i_op <= crs_pkg::OP_IRQ;
    @(posedge i_clk);
    i_op <= crs_pkg::OP_NOP;
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    chk({iy, cc}, 16'h00E8, "reset y cc");
    chk(sp, 16'h01FF, "reset sp");
    chk(pc, 16'h0000, "reset pc");
    chk({15'h0000, busy}, 16'h0000, "reset busy");
    $display("test mid reset done");
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // reset, then the scenarios in order
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    t_reset();
    t_regs();
    t_flags();
    t_wrap();
    t_ctx();
    t_mid_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
